/* File: core/fpeirq_consts.vh */
// Constants for the flash program/erase event and interrupt register bank
`ifndef FPEIRQ_CONSTS_VH
`define FPEIRQ_CONSTS_VH

`define FPEIRQ_ADDR_W 4
`define FPEIRQ_OFS_STATUS 4'h0
`define FPEIRQ_OFS_CTRL 4'h4
`define FPEIRQ_OFS_EVT 4'h8
`define FPEIRQ_OFS_EVT_EN 4'hC

`define FPEIRQ_BIT_PD_EN 7
`define FPEIRQ_BIT_PD 6
`define FPEIRQ_BIT_PF_EN 5
`define FPEIRQ_BIT_PF 4
`define FPEIRQ_BIT_ED_EN 3
`define FPEIRQ_BIT_ED 2
`define FPEIRQ_BIT_EF_EN 1
`define FPEIRQ_BIT_EF 0
`define FPEIRQ_FLAG_MASK 8'h55
`define FPEIRQ_STATUS_RST 8'h00

`define FPEIRQ_CTRL_RESET_CMD 0
`define FPEIRQ_CTRL_RMW 1

`define FPEIRQ_RESP_OKAY 2'h0
`define FPEIRQ_RESP_SLVERR 2'h2

`endif

/* File: core/fpeirq_status_reg.v */
// Status register core: flags, enables, block state and interrupt
`timescale 1ns/1ps
`include "fpeirq_consts.vh"
module fpeirq_status_reg (
	// Clock and reset
	input wire i_ref_clk,
	input wire i_srst,
	// Software write of the status byte
	input wire i_wr,
	input wire [7:0] i_wdata,
	// Software reset command
	input wire i_reset_cmd,
	// Algorithm end events (synchronised, one-cycle) and synchronised stuck level
	input wire i_prog_end,
	input wire i_erase_end,
	input wire i_stuck,
	// State
	output reg [7:0] o_status,
	output reg o_blocked,
	output reg o_irq
);
	reg [7:0] st_nxt;
	reg blk_nxt;
	wire prog_ok = i_prog_end & ~i_stuck;
	wire prog_bad = i_prog_end & i_stuck;
	wire erase_ok = i_erase_end & ~i_stuck;
	wire erase_bad = i_erase_end & i_stuck;

	always @* begin
		st_nxt = o_status;
		blk_nxt = o_blocked;
		if (i_wr) begin
			// Enables store as written; flags only accept a zero
			st_nxt = (i_wdata & ~`FPEIRQ_FLAG_MASK) |
				(o_status & i_wdata & `FPEIRQ_FLAG_MASK);
			// Clearing a completion flag locks out further operations
			if ((o_status[`FPEIRQ_BIT_PD] & ~i_wdata[`FPEIRQ_BIT_PD]) |
				(o_status[`FPEIRQ_BIT_ED] & ~i_wdata[`FPEIRQ_BIT_ED]))
				blk_nxt = 1'b1;
		end
		if (i_reset_cmd)
			blk_nxt = 1'b0;
		// Hardware events come last so a set beats a same-cycle clear
		if (prog_ok)
			st_nxt[`FPEIRQ_BIT_PD] = 1'b1;
		if (prog_bad) begin
			st_nxt[`FPEIRQ_BIT_PD] = 1'b0;
			st_nxt[`FPEIRQ_BIT_PF] = 1'b1;
			blk_nxt = 1'b1;
		end
		if (erase_ok)
			st_nxt[`FPEIRQ_BIT_ED] = 1'b1;
		if (erase_bad) begin
			st_nxt[`FPEIRQ_BIT_ED] = 1'b0;
			st_nxt[`FPEIRQ_BIT_EF] = 1'b1;
			blk_nxt = 1'b1;
		end
	end

	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_status <= `FPEIRQ_STATUS_RST;
			o_blocked <= 1'b0;
			o_irq <= 1'b0;
		end else begin
			o_status <= st_nxt;
			o_blocked <= blk_nxt;
			o_irq <= (st_nxt[`FPEIRQ_BIT_PD] & st_nxt[`FPEIRQ_BIT_PD_EN]) |
				(st_nxt[`FPEIRQ_BIT_PF] & st_nxt[`FPEIRQ_BIT_PF_EN]) |
				(st_nxt[`FPEIRQ_BIT_ED] & st_nxt[`FPEIRQ_BIT_ED_EN]) |
				(st_nxt[`FPEIRQ_BIT_EF] & st_nxt[`FPEIRQ_BIT_EF_EN]);
		end
	end
endmodule // fpeirq_status_reg

/* File: core/fpeirq_top.v */
// AXI4-Lite slave around the flash event status and interrupt register
`timescale 1ns/1ps
`include "fpeirq_consts.vh"
module fpeirq_top (
	// Clock and reset
	input wire i_ref_clk,
	input wire i_srst,
	// AXI4-Lite write address
	input wire i_awvalid,
	output reg o_awready,
	input wire [`FPEIRQ_ADDR_W-1:0] i_awaddr,
	// AXI4-Lite write data
	input wire i_wvalid,
	output reg o_wready,
	input wire [31:0] i_wdata,
	input wire [3:0] i_wstrb,
	// AXI4-Lite write response
	output reg o_bvalid,
	input wire i_bready,
	output reg [1:0] o_bresp,
	// AXI4-Lite read address
	input wire i_arvalid,
	output reg o_arready,
	input wire [`FPEIRQ_ADDR_W-1:0] i_araddr,
	// AXI4-Lite read data
	output reg o_rvalid,
	input wire i_rready,
	output reg [31:0] o_rdata,
	output reg [1:0] o_rresp,
	// Flash algorithm side, asynchronous to this clock
	input wire i_prog_end,
	input wire i_erase_end,
	input wire i_algorithm_stuck_indication,
	// Outputs
	output reg o_op_blocked,
	output reg o_irq
);
	// Three-stage synchronisers; an end event is a rise agreed by stages 2 and 3
	reg [2:0] pe_sync_r;
	reg [2:0] ee_sync_r;
	reg [2:0] st_sync_r;
	reg pe_lvl_r;
	reg ee_lvl_r;
	reg st_lvl_r;
	wire pe_pulse = pe_sync_r[1] & pe_sync_r[2] & ~pe_lvl_r;
	wire ee_pulse = ee_sync_r[1] & ee_sync_r[2] & ~ee_lvl_r;
	// Stuck level also waits for agreement, so a one-stage glitch cannot drop it early
	wire stuck_now = st_lvl_r;

	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			pe_sync_r <= 3'h0;
			ee_sync_r <= 3'h0;
			st_sync_r <= 3'h0;
			pe_lvl_r <= 1'b0;
			ee_lvl_r <= 1'b0;
			st_lvl_r <= 1'b0;
		end else begin
			pe_sync_r <= {pe_sync_r[1:0], i_prog_end};
			ee_sync_r <= {ee_sync_r[1:0], i_erase_end};
			st_sync_r <= {st_sync_r[1:0], i_algorithm_stuck_indication};
			if (pe_sync_r[1] == pe_sync_r[2])
				pe_lvl_r <= pe_sync_r[2];
			if (ee_sync_r[1] == ee_sync_r[2])
				ee_lvl_r <= ee_sync_r[2];
			if (st_sync_r[1] == st_sync_r[2])
				st_lvl_r <= st_sync_r[2];
		end
	end

	// Write channel: address and data latched in either order
	reg aw_held_r;
	reg w_held_r;
	reg [`FPEIRQ_ADDR_W-1:0] aw_addr_r;
	reg [7:0] w_data_r;
	reg w_strb0_r;
	reg ctrl_rmw_r;
	wire aw_take = i_awvalid & o_awready;
	wire w_take = i_wvalid & o_wready;
	wire aw_have = aw_held_r | aw_take;
	wire w_have = w_held_r | w_take;
	wire [`FPEIRQ_ADDR_W-1:0] wr_addr = aw_held_r ? aw_addr_r : i_awaddr;
	wire [7:0] wr_byte = w_held_r ? w_data_r : i_wdata[7:0];
	wire wr_lane0 = w_held_r ? w_strb0_r : i_wstrb[0];
	wire wr_go = aw_have & w_have & ~o_bvalid;
	wire wr_map = (wr_addr == `FPEIRQ_OFS_STATUS) | (wr_addr == `FPEIRQ_OFS_CTRL);
	wire st_wr = wr_go & wr_lane0 & (wr_addr == `FPEIRQ_OFS_STATUS);
	wire ctrl_wr = wr_go & wr_lane0 & (wr_addr == `FPEIRQ_OFS_CTRL);
	wire rst_cmd = ctrl_wr & wr_byte[`FPEIRQ_CTRL_RESET_CMD];

	wire [7:0] status;
	wire blocked;
	wire irq;

	fpeirq_status_reg u_reg (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_wr(st_wr),
		.i_wdata(wr_byte),
		.i_reset_cmd(rst_cmd),
		.i_prog_end(pe_pulse),
		.i_erase_end(ee_pulse),
		.i_stuck(stuck_now),
		.o_status(status),
		.o_blocked(blocked),
		.o_irq(irq)
	);

	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_awready <= 1'b0;
			o_wready <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= `FPEIRQ_RESP_OKAY;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= {`FPEIRQ_ADDR_W{1'b0}};
			w_data_r <= 8'h00;
			w_strb0_r <= 1'b0;
			ctrl_rmw_r <= 1'b0;
		end else begin
			o_awready <= ~aw_have & ~o_bvalid;
			o_wready <= ~w_have & ~o_bvalid;
			if (aw_take) begin
				aw_addr_r <= i_awaddr;
				aw_held_r <= 1'b1;
			end
			if (w_take) begin
				w_data_r <= i_wdata[7:0];
				w_strb0_r <= i_wstrb[0];
				w_held_r <= 1'b1;
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				o_awready <= 1'b0;
				o_wready <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= wr_map ? `FPEIRQ_RESP_OKAY : `FPEIRQ_RESP_SLVERR;
				if (ctrl_wr)
					ctrl_rmw_r <= wr_byte[`FPEIRQ_CTRL_RMW];
			end else if (o_bvalid & i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// Read channel
	reg [31:0] rd_val;
	always @* begin
		rd_val = 32'h0000_0000;
		case (i_araddr)
			`FPEIRQ_OFS_STATUS: begin
				// Read-modify-write mode reads flags as one so a later write keeps them
				rd_val[7:0] = ctrl_rmw_r ? (status | `FPEIRQ_FLAG_MASK) : status;
			end
			`FPEIRQ_OFS_CTRL: rd_val[`FPEIRQ_CTRL_RMW] = ctrl_rmw_r;
			`FPEIRQ_OFS_EVT: begin
				// Zero flags mean idle or busy; block state shown beside them
				rd_val[7:0] = status & `FPEIRQ_FLAG_MASK;
				rd_val[8] = blocked;
			end
			`FPEIRQ_OFS_EVT_EN: rd_val[7:0] = status & ~`FPEIRQ_FLAG_MASK;
			default: rd_val = 32'h0000_0000;
		endcase
	end
	wire rd_map = (i_araddr == `FPEIRQ_OFS_STATUS) | (i_araddr == `FPEIRQ_OFS_CTRL) |
		(i_araddr == `FPEIRQ_OFS_EVT) | (i_araddr == `FPEIRQ_OFS_EVT_EN);

	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= `FPEIRQ_RESP_OKAY;
			o_op_blocked <= 1'b0;
			o_irq <= 1'b0;
		end else begin
			o_op_blocked <= blocked;
			o_irq <= irq;
			o_arready <= ~o_rvalid & ~(i_arvalid & o_arready);
			if (i_arvalid & o_arready) begin
				o_rvalid <= 1'b1;
				o_rdata <= rd_val;
				o_rresp <= rd_map ? `FPEIRQ_RESP_OKAY : `FPEIRQ_RESP_SLVERR;
			end else if (o_rvalid & i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end
endmodule // fpeirq_top

/* File: verif/fpeirq_checker.sv */
// Assertions on the ports of the flash event register bank
`timescale 1ns/1ps
module fpeirq_checker (
	input wire i_ref_clk,
	input wire i_srst,
	input wire i_bready,
	input wire i_rready,
	input wire i_prog_end,
	input wire i_erase_end,
	input wire i_algorithm_stuck_indication,
	input wire o_bvalid,
	input wire [1:0] o_bresp,
	input wire o_rvalid,
	input wire [31:0] o_rdata,
	input wire o_op_blocked,
	input wire o_irq
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	logic [3:0] quiet_r;
	// Cycles since the last cause that may raise the interrupt
	always @(posedge i_ref_clk)
		quiet_r <= (i_srst | i_prog_end | i_erase_end | o_bvalid) ? 4'h0 :
			quiet_r + {3'h0, quiet_r != 4'hF};
	sequence stuck_end(ev);
		i_algorithm_stuck_indication[*4] ##1 ($rose(ev) && i_algorithm_stuck_indication);
	endsequence
	reset_zero_a: assert property ($fell(i_srst) |-> !o_irq && !o_op_blocked)
		else $error("outputs not zero after reset");
	prog_fail_a: assert property (stuck_end(i_prog_end) |-> ##[1:8] o_op_blocked)
		else $error("program failure did not block");
	erase_fail_a: assert property (stuck_end(i_erase_end) |-> ##[1:8] o_op_blocked)
		else $error("erase failure did not block");
	block_keep_a: assert property ($fell(o_op_blocked) |-> o_bvalid || $past(o_bvalid))
		else $error("block dropped without a write");
	// A failure may drop the done interrupt, but it blocks in the same cycle
	irq_clear_a: assert property ($fell(o_irq) |-> $past(o_bvalid) || o_op_blocked)
		else $error("interrupt dropped without a write");
	irq_cause_a: assert property ($rose(o_irq) |-> quiet_r < 4'h8)
		else $error("interrupt rose without cause");
	wresp_once_a: assert property (o_bvalid && i_bready |=> !o_bvalid)
		else $error("write response not ended by handshake");
	rdata_once_a: assert property (o_rvalid && i_rready |=> !o_rvalid)
		else $error("read data not ended by handshake");
endmodule // fpeirq_checker

bind fpeirq_top fpeirq_checker fpeirq_checker_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
	.i_bready(i_bready), .i_rready(i_rready), .i_prog_end(i_prog_end),
	.i_erase_end(i_erase_end), .i_algorithm_stuck_indication(i_algorithm_stuck_indication),
	.o_bvalid(o_bvalid), .o_bresp(o_bresp), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
	.o_op_blocked(o_op_blocked), .o_irq(o_irq));

/* File: verif/fpeirq_flash_model.sv */
// Behavioural flash macro driving the algorithm end and stuck lines
`timescale 1ns/1ps
module fpeirq_flash_model (
	input wire i_ref_clk,
	output logic o_prog_end,
	output logic o_erase_end,
	output logic o_stuck
);
	initial begin
		o_prog_end = 1'b0;
		o_erase_end = 1'b0;
		o_stuck = 1'b0;
	end
	// Stuck settles five cycles ahead of the end rise so the sampler sees it
	task automatic run(input bit erase, input bit fail, input int busy);
		repeat (busy) @(posedge i_ref_clk);
		o_stuck <= fail;
		repeat (5) @(posedge i_ref_clk);
		if (erase)
			o_erase_end <= 1'b1;
		else
			o_prog_end <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		o_prog_end <= 1'b0;
		o_erase_end <= 1'b0;
		o_stuck <= 1'b0;
	endtask
endmodule // fpeirq_flash_model

/* File: verif/tb_flash_prog_erase_irq_status.sv */
// Self-checking bench for the flash event register bank
`timescale 1ns/1ps
module tb_flash_prog_erase_irq_status;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	wire awready, wready, bvalid, arready, rvalid, pe, ee, st, blocked, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int failures = 0, checks_done = 0;
	initial forever #4 clk = ~clk;
	fpeirq_top fpeirq_top_i (.i_ref_clk(clk), .i_srst(srst), .i_awvalid(awvalid),
		.o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
		.i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bready),
		.o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
		.o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
		.i_prog_end(pe), .i_erase_end(ee), .i_algorithm_stuck_indication(st),
		.o_op_blocked(blocked), .o_irq(irq));
	fpeirq_flash_model fpeirq_flash_model_i (.i_ref_clk(clk), .o_prog_end(pe),
		.o_erase_end(ee), .o_stuck(st));
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d, logic [1:0] er);
		int n = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end while (!bvalid && n < 50);
		chk("bvalid", 1, bvalid);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge clk);
	endtask
	task automatic rchk(string nm, logic [3:0] a, logic [31:0] e);
		int n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			n++;
		end while (!rvalid && n < 50);
		chk("rvalid", 1, rvalid);
		rready <= 1'b0;
		chk(nm, e, rdata);
		chk("rresp", (a[1:0] != 2'h0) ? 32'h2 : 32'h0, {30'h0, rresp});
		@(posedge clk);
	endtask
	task automatic op(bit erase, bit fail, int busy);
		fpeirq_flash_model_i.run(erase, fail, busy);
		repeat (4) @(posedge clk);
	endtask
	task automatic t_done();
		rchk("reset", 4'h0, 32'h0);
		wr(4'h0, 8'h80, 2'h0);
		op(1'b0, 1'b0, 2);
		rchk("prog done", 4'h0, 32'hC0);
		chk("irq", 1, irq);
		wr(4'h0, 8'hC0, 2'h0);
		rchk("flag kept", 4'h0, 32'hC0);
		wr(4'h0, 8'h80, 2'h0);
		chk("irq off", 0, irq);
		chk("block", 1, blocked);
		wr(4'h4, 8'h01, 2'h0);
		chk("unblock", 0, blocked);
		$display("test done flags finished");
	endtask
	task automatic t_erase();
		op(1'b1, 1'b0, 20);
		chk("irq masked", 0, irq);
		wr(4'h0, 8'h0C, 2'h0);
		chk("irq", 1, irq);
		wr(4'h4, 8'h02, 2'h0);
		rchk("rmw mode", 4'h4, 32'h02);
		rchk("rmw", 4'h0, 32'h5D);
		wr(4'h4, 8'h00, 2'h0);
		wr(4'h0, 8'h08, 2'h0);
		rchk("cleared", 4'h0, 32'h08);
		wr(4'h4, 8'h01, 2'h0);
		$display("test erase finished");
	endtask
	task automatic t_fail();
		wr(4'h0, 8'h22, 2'h0);
		op(1'b0, 1'b0, 2);
		op(1'b0, 1'b1, 2);
		rchk("prog fail", 4'h0, 32'h32);
		chk("irq", 1, irq);
		chk("block", 1, blocked);
		wr(4'hC, 8'h00, 2'h2);
		rchk("enables", 4'hC, 32'h22);
		wr(4'h0, 8'h22, 2'h0);
		wr(4'h4, 8'h01, 2'h0);
		op(1'b1, 1'b0, 2);
		op(1'b1, 1'b1, 2);
		rchk("erase fail", 4'h0, 32'h23);
		chk("irq", 1, irq);
		chk("block", 1, blocked);
		$display("test failures finished");
	endtask
	task automatic t_reset();
		rchk("event view", 4'h8, 32'h101);
		rchk("unmapped", 4'h2, 32'h0);
		// Held four cycles so the outputs falling under reset stay masked
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk("irq reset", 0, irq);
		chk("block reset", 0, blocked);
		rchk("reset again", 4'h0, 32'h0);
		$display("test reset finished");
	endtask
	task automatic close_out();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_done();
		t_erase();
		t_fail();
		t_reset();
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		close_out();
	end
endmodule // tb_flash_prog_erase_irq_status
